// File: core/phy_status_pkg.sv
package phy_status_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] BASIC_STATUS_IDX   = 8'h01;
  localparam logic [7:0] NEG_EXPANSION_IDX  = 8'h06;
  localparam logic [7:0] STATUS_SUMMARY_IDX = 8'h10;
  localparam logic [7:0] INT_STATUS_EVT_IDX = 8'h12;
  localparam logic [7:0] FALSE_CARRIER_IDX  = 8'h14;
  localparam logic [7:0] RX_ERROR_COUNT_IDX = 8'h15;
  localparam logic [7:0] TEN_MEG_STATUS_IDX = 8'h1A;
  localparam logic [7:0] EVT_STATUS_IDX     = 8'h20;
  localparam logic [7:0] EVT_MASK_IDX       = 8'h21;
  localparam logic [7:0] PHY_CONTROL_IDX    = 8'h22;

  // summary register field positions
  localparam int SUM_RSVD      = 15;
  localparam int SUM_MDIX      = 14;
  localparam int SUM_RX_ERR    = 13;
  localparam int SUM_POLARITY  = 12;
  localparam int SUM_FALSE_CAR = 11;
  localparam int SUM_SIG_DET   = 10;
  localparam int SUM_DESC_LOCK = 9;
  localparam int SUM_PAGE_RX   = 8;
  localparam int SUM_INT_PEND  = 7;
  localparam int SUM_REM_FAULT = 6;
  localparam int SUM_JABBER    = 5;
  localparam int SUM_AN_DONE   = 4;
  localparam int SUM_LOOPBACK  = 3;
  localparam int SUM_DUPLEX    = 2;
  localparam int SUM_SPEED10   = 1;
  localparam int SUM_LINK      = 0;

  // other field positions
  localparam int TEN_MEG_POL_BIT   = 4;
  localparam int NEG_EXP_PAGE_BIT  = 1;
  localparam int BASIC_LINK_BIT    = 2;
  localparam int BASIC_FAULT_BIT   = 4;
  localparam int BASIC_AN_DONE_BIT = 5;
  localparam int CTRL_XOVER_EN     = 0;
  localparam int CTRL_XOVER_FORCE  = 1;

  // latched status bits, one entry each
  localparam int LATCH_RX_ERR    = 0;
  localparam int LATCH_FALSE_CAR = 1;
  localparam int LATCH_POLARITY  = 2;
  localparam int LATCH_SIG_DET   = 3;
  localparam int LATCH_DESC_LOCK = 4;
  localparam int LATCH_PAGE_RX   = 5;
  localparam int LATCH_REM_FAULT = 6;
  localparam int LATCH_COUNT     = 7;
  // one marks latched-high, zero marks latched-low
  localparam logic [LATCH_COUNT-1:0] LATCH_ACTIVE = 7'h67;

  // event status bits
  localparam int EVT_COUNT = 6;
  localparam int EVT_LINK  = 5;

  // values after reset, and the counter ceiling
  localparam logic [15:0] DATA_RESET    = 16'h0000;
  localparam logic [1:0]  CTRL_RESET    = 2'h1;
  localparam logic [7:0]  COUNT_RESET   = 8'h00;
  localparam logic [7:0]  COUNT_MAX     = 8'hFF;

  // live state from the rest of the transceiver, same clock
  typedef struct packed {
    logic mdixSwapped;
    logic rxErrEvt;
    logic falseCarrierEvt;
    logic polarityInverted;
    logic signalDetect;
    logic descramblerLock;
    logic pageRxEvt;
    logic remoteFault;
    logic jabber;
    logic anComplete;
    logic loopback;
    logic fullDuplex;
    logic speed10;
    logic linkUp;
  } phyLive_t;

endpackage

// File: core/sticky_status_bit.sv
`timescale 1ns/1ps
module sticky_status_bit
#(
  parameter logic ACTIVE = 1'b1
)
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic live,
  input  wire logic clear,
  output logic      value
);

  logic heldFf;
  logic nxt_heldFf;

  // an active level wins over a clearing read in the same cycle
  always_comb
  begin
    nxt_heldFf = heldFf;
    if (live == ACTIVE)
    begin
      nxt_heldFf = 1'b1;
    end
    else if (clear)
    begin
      nxt_heldFf = 1'b0;
    end
  end

  // latched-low bits start held so they read zero out of reset
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      heldFf <= ~ACTIVE;
    end
    else
    begin
      heldFf <= nxt_heldFf;
    end
  end

  // held shows the active level, otherwise the live source
  assign value = heldFf ? ACTIVE : live;

endmodule

// File: core/phy_status_summary_register.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module phy_status_summary_register
(
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire phy_status_pkg::phyLive_t phy,
  output logic                          irq
);
  import phy_status_pkg::*;

  logic [7:0]             regIdx;
  logic                   addrOk;
  logic                   setupRead;
  logic                   accessWrite;
  logic [LATCH_COUNT-1:0] latchLive;
  logic [LATCH_COUNT-1:0] latchClr;
  logic [LATCH_COUNT-1:0] latchVal;
  logic [EVT_COUNT-1:0]   evtRaw;
  logic [EVT_COUNT-1:0]   nxt_evtStatusFf;
  logic [EVT_COUNT-1:0]   evtStatusFf;
  logic [EVT_COUNT-1:0]   evtMaskFf;
  logic [1:0]             ctrlFf;
  logic [7:0]             rxErrCountFf;
  logic [7:0]             falseCarCountFf;
  logic                   intPendFf;
  logic                   linkPrevFf;
  logic                   mdixBit;
  logic [15:0]            summaryWord;
  logic [15:0]            readWord;
  logic [31:0]            prdataFf;
  logic                   slvErrFf;
  logic                   rdSummary;
  logic                   rdBasic;
  logic                   rdExpansion;
  logic                   rdIntStatus;
  logic                   rdFalseCar;
  logic                   rdRxErr;
  logic                   rdTenMeg;
  logic                   newUnmasked;

  // bus decode; read side effects act at the edge that captures data
  assign regIdx      = paddr[9:2];
  assign setupRead   = psel && !penable && !pwrite;
  assign accessWrite = psel && penable && pwrite && addrOk;
  assign rdSummary   = setupRead && (regIdx == STATUS_SUMMARY_IDX);
  assign rdBasic     = setupRead && (regIdx == BASIC_STATUS_IDX);
  assign rdExpansion = setupRead && (regIdx == NEG_EXPANSION_IDX);
  assign rdIntStatus = setupRead && (regIdx == INT_STATUS_EVT_IDX);
  assign rdFalseCar  = setupRead && (regIdx == FALSE_CARRIER_IDX);
  assign rdRxErr     = setupRead && (regIdx == RX_ERROR_COUNT_IDX);
  assign rdTenMeg    = setupRead && (regIdx == TEN_MEG_STATUS_IDX);

  always_comb
  begin
    addrOk = 1'b0;
    if (paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0)
    begin
      case (regIdx)
        BASIC_STATUS_IDX, NEG_EXPANSION_IDX, STATUS_SUMMARY_IDX,
        INT_STATUS_EVT_IDX, FALSE_CARRIER_IDX, RX_ERROR_COUNT_IDX,
        TEN_MEG_STATUS_IDX, EVT_STATUS_IDX, EVT_MASK_IDX,
        PHY_CONTROL_IDX: addrOk = 1'b1;
        default:         addrOk = 1'b0;
      endcase
    end
  end

  // latched bits, sources and clearing reads
  always_comb
  begin
    latchLive                  = '0;
    latchClr                   = '0;
    latchLive[LATCH_RX_ERR]    = phy.rxErrEvt;
    latchClr[LATCH_RX_ERR]     = rdRxErr;
    latchLive[LATCH_FALSE_CAR] = phy.falseCarrierEvt;
    latchClr[LATCH_FALSE_CAR]  = rdFalseCar;
    latchLive[LATCH_POLARITY]  = phy.polarityInverted;
    latchClr[LATCH_POLARITY]   = rdTenMeg;
    latchLive[LATCH_SIG_DET]   = phy.signalDetect;
    latchClr[LATCH_SIG_DET]    = rdSummary;
    latchLive[LATCH_DESC_LOCK] = phy.descramblerLock;
    latchClr[LATCH_DESC_LOCK]  = rdSummary;
    latchLive[LATCH_PAGE_RX]   = phy.pageRxEvt;
    latchClr[LATCH_PAGE_RX]    = rdExpansion;
    latchLive[LATCH_REM_FAULT] = phy.remoteFault;
    latchClr[LATCH_REM_FAULT]  = rdBasic;
  end

  genvar gi;
  generate
    for (gi = 0; gi < LATCH_COUNT; gi++)
    begin : g_latch
      sticky_status_bit
      #(
        .ACTIVE (LATCH_ACTIVE[gi])
      )
      u_bit
      (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .live     (latchLive[gi]),
        .clear    (latchClr[gi]),
        .value    (latchVal[gi])
      );
    end
  endgenerate

  // crossover: forced swaps, disabled stays normal, else live
  assign mdixBit = ctrlFf[CTRL_XOVER_FORCE] ? 1'b1 :
                   ctrlFf[CTRL_XOVER_EN]    ? phy.mdixSwapped :
                                              1'b0;

  always_comb
  begin
    summaryWord                = DATA_RESET;
    summaryWord[SUM_RSVD]      = 1'b0;
    summaryWord[SUM_MDIX]      = mdixBit;
    summaryWord[SUM_RX_ERR]    = latchVal[LATCH_RX_ERR];
    summaryWord[SUM_POLARITY]  = latchVal[LATCH_POLARITY];
    summaryWord[SUM_FALSE_CAR] = latchVal[LATCH_FALSE_CAR];
    summaryWord[SUM_SIG_DET]   = latchVal[LATCH_SIG_DET];
    summaryWord[SUM_DESC_LOCK] = latchVal[LATCH_DESC_LOCK];
    summaryWord[SUM_PAGE_RX]   = latchVal[LATCH_PAGE_RX];
    summaryWord[SUM_INT_PEND]  = intPendFf;
    summaryWord[SUM_REM_FAULT] = latchVal[LATCH_REM_FAULT];
    summaryWord[SUM_JABBER]    = phy.jabber;
    summaryWord[SUM_AN_DONE]   = phy.anComplete;
    summaryWord[SUM_LOOPBACK]  = phy.loopback;
    summaryWord[SUM_DUPLEX]    = phy.fullDuplex;
    summaryWord[SUM_SPEED10]   = phy.speed10;
    summaryWord[SUM_LINK]      = phy.linkUp;
  end

  // read mux
  always_comb
  begin
    readWord = DATA_RESET;
    case (regIdx)
      STATUS_SUMMARY_IDX: readWord = summaryWord;
      BASIC_STATUS_IDX:
      begin
        readWord[BASIC_LINK_BIT]    = phy.linkUp;
        readWord[BASIC_FAULT_BIT]   = latchVal[LATCH_REM_FAULT];
        readWord[BASIC_AN_DONE_BIT] = phy.anComplete;
      end
      NEG_EXPANSION_IDX:
        readWord[NEG_EXP_PAGE_BIT] = latchVal[LATCH_PAGE_RX];
      TEN_MEG_STATUS_IDX:
        readWord[TEN_MEG_POL_BIT] = latchVal[LATCH_POLARITY];
      INT_STATUS_EVT_IDX: readWord[EVT_COUNT-1:0] = evtStatusFf;
      EVT_STATUS_IDX:     readWord[EVT_COUNT-1:0] = evtStatusFf;
      EVT_MASK_IDX:       readWord[EVT_COUNT-1:0] = evtMaskFf;
      PHY_CONTROL_IDX:    readWord[1:0] = ctrlFf;
      FALSE_CARRIER_IDX:  readWord[7:0] = falseCarCountFf;
      RX_ERROR_COUNT_IDX: readWord[7:0] = rxErrCountFf;
      default:            readWord = DATA_RESET;
    endcase
  end

  // bus answer registered in the setup cycle, zero wait states
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdataFf <= '0;
      slvErrFf <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdataFf <= {16'h0000, (addrOk ? readWord : DATA_RESET)};
      slvErrFf <= !addrOk;
    end
  end

  assign prdata  = prdataFf;
  assign pslverr = psel && penable && slvErrFf;
  assign pready  = 1'b1;

  // software control: crossover settings, event mask
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrlFf    <= CTRL_RESET;
      evtMaskFf <= '0;
    end
    else if (accessWrite)
    begin
      if (regIdx == PHY_CONTROL_IDX)
      begin
        ctrlFf <= pwdata[1:0];
      end
      if (regIdx == EVT_MASK_IDX)
      begin
        evtMaskFf <= pwdata[EVT_COUNT-1:0];
      end
    end
  end

  // event counters, saturating, cleared by their own read
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxErrCountFf    <= COUNT_RESET;
      falseCarCountFf <= COUNT_RESET;
    end
    else
    begin
      if (phy.rxErrEvt && (rxErrCountFf != COUNT_MAX || rdRxErr))
        rxErrCountFf <= rdRxErr ? 8'h01 : rxErrCountFf + 8'h01;
      else if (rdRxErr)
        rxErrCountFf <= COUNT_RESET;
      if (phy.falseCarrierEvt && (falseCarCountFf != COUNT_MAX || rdFalseCar))
        falseCarCountFf <= rdFalseCar ? 8'h01 : falseCarCountFf + 8'h01;
      else if (rdFalseCar)
        falseCarCountFf <= COUNT_RESET;
    end
  end

  // sticky events, write one to clear, set wins
  assign evtRaw = {phy.linkUp != linkPrevFf, phy.remoteFault,
                   phy.pageRxEvt, phy.polarityInverted,
                   phy.falseCarrierEvt, phy.rxErrEvt};

  always_comb
  begin
    nxt_evtStatusFf = evtStatusFf;
    if (accessWrite && regIdx == EVT_STATUS_IDX)
    begin
      nxt_evtStatusFf = evtStatusFf & ~pwdata[EVT_COUNT-1:0];
    end
    nxt_evtStatusFf = nxt_evtStatusFf | evtRaw;
  end

  assign newUnmasked = |(evtRaw & evtMaskFf & ~evtStatusFf);

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      evtStatusFf <= '0;
      linkPrevFf  <= 1'b0;
    end
    else
    begin
      evtStatusFf <= nxt_evtStatusFf;
      linkPrevFf  <= phy.linkUp;
    end
  end

  // pending flag: new unmasked event sets, status read clears
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      intPendFf <= 1'b0;
    end
    else if (newUnmasked)
    begin
      intPendFf <= 1'b1;
    end
    else if (rdIntStatus)
    begin
      intPendFf <= 1'b0;
    end
  end

  assign irq = |(evtStatusFf & evtMaskFf);

  topBitZero_a : assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (psel && penable) |-> (prdata[SUM_RSVD] == 1'b0 || !(
      $past(regIdx) == STATUS_SUMMARY_IDX)))
    else $error("summary top bit read as one");
  mdixLive_a : assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (rdSummary && ctrlFf == 2'h1) |=> prdata[SUM_MDIX] ==
      $past(phy.mdixSwapped))
    else $error("crossover bit does not follow algorithm");
  mdixFixed_a : assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (rdSummary && !ctrlFf[CTRL_XOVER_EN]) |=> prdata[SUM_MDIX] ==
      $past(ctrlFf[CTRL_XOVER_FORCE]))
    else $error("crossover bit ignores fixed setting");
  rxErrHold_a : assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (phy.rxErrEvt ##1 !rdRxErr) |=> summaryWord[SUM_RX_ERR])
    else $error("receive error latch lost");
  polarityKeep_a : assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (rdSummary && summaryWord[SUM_POLARITY]) |=>
      summaryWord[SUM_POLARITY])
    else $error("polarity cleared by summary read");
  falseCarHold_a : assert property (
    @(posedge core_clk) disable iff (!rst_b)
    phy.falseCarrierEvt |=> summaryWord[SUM_FALSE_CAR])
    else $error("false carrier latch lost");
  sigDetLow_a : assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (!phy.signalDetect ##1 !rdSummary) |=>
      !summaryWord[SUM_SIG_DET])
    else $error("signal detect low not latched");
  lockLow_a : assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !phy.descramblerLock |=> !summaryWord[SUM_DESC_LOCK])
    else $error("descrambler lock low not latched");
  pageRxHold_a : assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (phy.pageRxEvt ##1 (!rdExpansion)[*2]) |=>
      summaryWord[SUM_PAGE_RX])
    else $error("page received cleared too early");
  intPendClr_a : assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (rdIntStatus && !newUnmasked) |=> !summaryWord[SUM_INT_PEND])
    else $error("pending not cleared by status read");
  faultClr_a : assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (rdBasic && !phy.remoteFault) ##1 !phy.remoteFault |->
      !summaryWord[SUM_REM_FAULT])
    else $error("remote fault not cleared by basic read");
  resetZero_a : assert property (
    @(posedge core_clk)
    $rose(rst_b) |-> prdataFf == 32'h0000_0000 && !intPendFf)
    else $error("state not zero after reset");
  linkMirror_a : assert property (
    @(posedge core_clk) disable iff (!rst_b)
    rdSummary |=> prdata[SUM_LINK] == $past(phy.linkUp))
    else $error("link bit does not mirror link");
  irqLevel_a : assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (phy.rxErrEvt && evtMaskFf[0]) |=> irq)
    else $error("unmasked event raised no interrupt");

endmodule

// File: test/apb_mgmt_master.sv
`timescale 1ns/1ps
// station management side: one APB transfer at a time
module apb_mgmt_master
(
  input  wire logic        core_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // setup, then access held until pready is seen high at an edge
  task automatic xfer(input logic wr, input logic [11:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata,
                      output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  import phy_status_pkg::*;
  logic        core_clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] d;
  logic        e;
  phyLive_t    phyIn;
  int          errors;
  int          checks;

  phy_status_summary_register i_phy_status_summary_register
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .phy      (phyIn),
    .irq      (irq)
  );

  apb_mgmt_master i_apb_mgmt_master
  (
    .core_clk (core_clk),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic rd(input logic [7:0] idx);
    i_apb_mgmt_master.xfer(1'b0, ba(idx), 32'h0, d, e);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    i_apb_mgmt_master.xfer(1'b1, ba(idx), v, d, e);
  endtask

  task automatic chk(input string name, input logic [31:0] got,
                     input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #(50 * 5000);
    errors++;
    report_and_stop();
  end

  initial
  begin
    errors = 0;
    checks = 0;
    rst_b = 1'b0;
    phyIn = '0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(STATUS_SUMMARY_IDX);
    chk("summary reset", d, 32'h0000_0000);
    wr(STATUS_SUMMARY_IDX, 32'h0000_FFFF);
    rd(STATUS_SUMMARY_IDX);
    chk("top bit", d & 32'h8000, 32'h0);
    // crossover: enabled follows live, forced swapped, disabled normal
    phyIn.mdixSwapped <= 1'b1;
    rd(STATUS_SUMMARY_IDX);
    chk("mdix live swapped", d & 32'h4000, 32'h4000);
    phyIn.mdixSwapped <= 1'b0;
    rd(STATUS_SUMMARY_IDX);
    chk("mdix live normal", d & 32'h4000, 32'h0);
    wr(PHY_CONTROL_IDX, 32'h3);
    rd(STATUS_SUMMARY_IDX);
    chk("mdix forced", d & 32'h4000, 32'h4000);
    phyIn.mdixSwapped <= 1'b1;
    wr(PHY_CONTROL_IDX, 32'h0);
    rd(STATUS_SUMMARY_IDX);
    chk("mdix disabled", d & 32'h4000, 32'h0);
    wr(PHY_CONTROL_IDX, 32'h1);
    // latched-low signal detect and descrambler lock
    phyIn.signalDetect <= 1'b1;
    phyIn.descramblerLock <= 1'b1;
    rd(STATUS_SUMMARY_IDX);
    rd(STATUS_SUMMARY_IDX);
    chk("low latch live", d & 32'h0600, 32'h0600);
    phyIn.signalDetect <= 1'b0;
    phyIn.descramblerLock <= 1'b0;
    @(posedge core_clk);
    phyIn.signalDetect <= 1'b1;
    phyIn.descramblerLock <= 1'b1;
    rd(STATUS_SUMMARY_IDX);
    chk("low latch held", d & 32'h0600, 32'h0);
    rd(STATUS_SUMMARY_IDX);
    chk("low latch back", d & 32'h0600, 32'h0600);
    // receive error and false carrier latches
    phyIn.rxErrEvt <= 1'b1;
    phyIn.falseCarrierEvt <= 1'b1;
    @(posedge core_clk);
    phyIn.rxErrEvt <= 1'b0;
    phyIn.falseCarrierEvt <= 1'b0;
    rd(STATUS_SUMMARY_IDX);
    rd(STATUS_SUMMARY_IDX);
    chk("high latches held", d & 32'h2800, 32'h2800);
    rd(RX_ERROR_COUNT_IDX);
    chk("rx error count", d, 32'h1);
    rd(STATUS_SUMMARY_IDX);
    chk("rx latch cleared", d & 32'h2800, 32'h0800);
    rd(FALSE_CARRIER_IDX);
    chk("false carrier count", d, 32'h1);
    rd(STATUS_SUMMARY_IDX);
    chk("fc latch cleared", d & 32'h0800, 32'h0);
    // polarity, page received, remote fault
    phyIn.polarityInverted <= 1'b1;
    phyIn.pageRxEvt <= 1'b1;
    phyIn.remoteFault <= 1'b1;
    phyIn.linkUp <= 1'b1;
    phyIn.anComplete <= 1'b1;
    @(posedge core_clk);
    phyIn.polarityInverted <= 1'b0;
    phyIn.pageRxEvt <= 1'b0;
    phyIn.remoteFault <= 1'b0;
    rd(STATUS_SUMMARY_IDX);
    rd(STATUS_SUMMARY_IDX);
    chk("mirrors held", d & 32'h1140, 32'h1140);
    rd(TEN_MEG_STATUS_IDX);
    chk("ten meg polarity", d & 32'h10, 32'h10);
    rd(NEG_EXPANSION_IDX);
    chk("expansion page", d & 32'h2, 32'h2);
    rd(STATUS_SUMMARY_IDX);
    chk("polarity page cleared", d & 32'h1140, 32'h0040);
    rd(BASIC_STATUS_IDX);
    chk("basic status", d & 32'h34, 32'h34);
    rd(STATUS_SUMMARY_IDX);
    chk("fault cleared", d & 32'h0040, 32'h0);
    // low bits: link, speed, duplex, negotiation complete
    phyIn.speed10 <= 1'b1;
    phyIn.fullDuplex <= 1'b1;
    phyIn.jabber <= 1'b1;
    phyIn.loopback <= 1'b1;
    rd(STATUS_SUMMARY_IDX);
    rd(STATUS_SUMMARY_IDX);
    chk("low bits", d & 32'h3F, 32'h3F);
    phyIn.speed10 <= 1'b0;
    phyIn.fullDuplex <= 1'b0;
    phyIn.anComplete <= 1'b0;
    phyIn.jabber <= 1'b0;
    phyIn.loopback <= 1'b0;
    rd(STATUS_SUMMARY_IDX);
    chk("low bits 100 half", d & 32'h3F, 32'h01);
    // interrupt: raise, read source, clear, mask
    wr(EVT_STATUS_IDX, 32'h3F);
    wr(EVT_MASK_IDX, 32'h01);
    rd(INT_STATUS_EVT_IDX);
    @(negedge core_clk);
    chk("irq idle", {31'h0, irq}, 32'h0);
    @(posedge core_clk);
    phyIn.rxErrEvt <= 1'b1;
    @(posedge core_clk);
    phyIn.rxErrEvt <= 1'b0;
    @(negedge core_clk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rd(STATUS_SUMMARY_IDX);
    chk("pending set", d & 32'h80, 32'h80);
    rd(INT_STATUS_EVT_IDX);
    chk("event source", d & 32'h1, 32'h1);
    rd(STATUS_SUMMARY_IDX);
    chk("pending cleared", d & 32'h80, 32'h0);
    wr(EVT_STATUS_IDX, 32'h01);
    @(negedge core_clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    @(posedge core_clk);
    phyIn.falseCarrierEvt <= 1'b1;
    @(posedge core_clk);
    phyIn.falseCarrierEvt <= 1'b0;
    @(negedge core_clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rd(STATUS_SUMMARY_IDX);
    chk("pending masked", d & 32'h80, 32'h0);
    // unmapped address
    i_apb_mgmt_master.xfer(1'b0, 12'h3FC, 32'h0, d, e);
    chk("unmapped error", {31'h0, e}, 32'h1);
    chk("unmapped data", d, 32'h0);
    report_and_stop();
  end
endmodule
